// ### dmacr_regs.vh
// register map and constants of the dma channel register slice
// What this block does
// - a 32-bit read/write destination start address, zero at reset.
// - source size: 16-bit byte count, zero at reset, bits 31:16 read 0.
// - the source size is a plain byte count; all ones is 65,535 bytes.
// - destination size: 16-bit byte count, zero at reset, top half 0.
// - a read-only 16-bit source pointer, zero at reset, top half reads 0.
// - in pattern-detect mode a pattern match resets the source pointer.
// - source done when pointer reaches size, half empty at half size.
// - block complete when the larger size is moved or on a match.
`ifndef DMACR_REGS_VH
`define DMACR_REGS_VH
`define DMACR_OFF_DST_START 8'h00
`define DMACR_OFF_SRC_SIZE 8'h04
`define DMACR_OFF_DST_SIZE 8'h08
`define DMACR_OFF_SRC_PTR 8'h0c
`define DMACR_OFF_CTRL 8'h10
`define DMACR_OFF_STAT 8'h14
`define DMACR_OFF_MASK 8'h18
`define DMACR_CTRL_EN 0
`define DMACR_CTRL_PAT 1
`define DMACR_FLAG_SDONE 7
`define DMACR_FLAG_SHALF 6
`define DMACR_FLAG_BLOCK 3
`define DMACR_FLAG_IMPL 8'hc8
`define DMACR_RST_WORD 32'h0000_0000
`define DMACR_RST_HALF 16'h0000
`define DMACR_RST_FLAGS 8'h00
`define DMACR_RST_CTRL 2'b00
`define DMACR_RST_COUNT 17'h00000
`endif

// ### dmacr_irq.v
// sticky event flags, mask and level interrupt
`timescale 1ns/1ps
`include "dmacr_regs.vh"
module dmacr_irq (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [7:0] i_set,
  input wire i_clr_we,
  input wire [7:0] i_clr_data,
  input wire i_mask_we,
  input wire [7:0] i_mask_data,
  output reg [7:0] o_status,
  output reg [7:0] o_mask,
  output wire o_irq
);
  wire [7:0] clr;
  assign clr = i_clr_we ? i_clr_data : 8'h00;

  // set wins over write-one-to-clear
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_status <= `DMACR_RST_FLAGS;
      o_mask <= `DMACR_RST_FLAGS;
    end else begin
      o_status <= ((o_status & ~clr) | i_set) & `DMACR_FLAG_IMPL;
      if (i_mask_we) begin
        o_mask <= i_mask_data & `DMACR_FLAG_IMPL;
      end
    end
  end

  assign o_irq = |(o_status & o_mask);
endmodule // dmacr_irq

// ### dmacr_top.v
// apb register slice and byte engine of one dma channel
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dmacr_regs.vh"
module dmacr_top (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output reg o_pslverr,
  input wire [31:0] i_src_start,
  output wire o_src_req,
  output wire [31:0] o_src_addr,
  output wire [31:0] o_dst_addr,
  input wire i_src_ack,
  input wire [2:0] i_src_nbytes,
  input wire i_pattern_match,
  output wire o_busy,
  output wire o_irq
);
  reg [31:0] dst_start;
  reg [15:0] src_size;
  reg [15:0] dst_size;
  reg [15:0] src_ptr;
  reg [15:0] dst_ptr;
  reg [16:0] moved;
  reg [1:0] ctrl;
  wire [7:0] status;
  wire [7:0] mask;
  wire [7:0] events;
  reg [31:0] next_prdata;

  wire setup;
  wire wr;
  wire [16:0] next_src_ptr;
  wire [16:0] next_dst_ptr;
  wire [16:0] next_moved;
  wire [16:0] block_len;
  wire [15:0] src_half;
  wire step;
  wire pat_hit;
  wire ev_sdone;
  wire ev_shalf;
  wire ev_block;
  wire ev_ddone;
  wire ev_moved;
  wire wr_dst_start;
  wire wr_src_size;
  wire wr_dst_size;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;

  function mapped;
    input [7:0] addr;
    begin
      case (addr)
        `DMACR_OFF_DST_START,
        `DMACR_OFF_SRC_SIZE,
        `DMACR_OFF_DST_SIZE,
        `DMACR_OFF_SRC_PTR,
        `DMACR_OFF_CTRL,
        `DMACR_OFF_STAT,
        `DMACR_OFF_MASK: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function [16:0] add_bytes;
    input [15:0] base;
    input [2:0] nb;
    begin
      add_bytes = {1'b0, base} + {14'h0000, nb};
    end
  endfunction

  // apb: zero wait states, read data captured in the setup phase
  assign o_pready = 1'b1;
  assign setup = i_psel & ~i_penable;
  assign wr = i_psel & i_penable & i_pwrite & mapped(i_paddr);

  // write strobes, one per writable register
  assign wr_dst_start = wr & (i_paddr == `DMACR_OFF_DST_START);
  assign wr_src_size = wr & (i_paddr == `DMACR_OFF_SRC_SIZE);
  assign wr_dst_size = wr & (i_paddr == `DMACR_OFF_DST_SIZE);
  assign wr_ctrl = wr & (i_paddr == `DMACR_OFF_CTRL);
  assign wr_stat = wr & (i_paddr == `DMACR_OFF_STAT);
  assign wr_mask = wr & (i_paddr == `DMACR_OFF_MASK);

  // read mux
  always @* begin
    next_prdata = `DMACR_RST_WORD;
    case (i_paddr)
      `DMACR_OFF_DST_START: next_prdata = dst_start;
      `DMACR_OFF_SRC_SIZE: next_prdata = {16'h0000, src_size};
      `DMACR_OFF_DST_SIZE: next_prdata = {16'h0000, dst_size};
      `DMACR_OFF_SRC_PTR: next_prdata = {16'h0000, src_ptr};
      `DMACR_OFF_CTRL: next_prdata = {30'h00000000, ctrl};
      `DMACR_OFF_STAT: next_prdata = {24'h000000, status};
      `DMACR_OFF_MASK: next_prdata = {24'h000000, mask};
      default: next_prdata = `DMACR_RST_WORD;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= `DMACR_RST_WORD;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pslverr <= ~mapped(i_paddr);
      o_prdata <= next_prdata;
    end
  end

  // engine arithmetic
  assign src_half = src_size >> 1;
  assign block_len = (src_size > dst_size) ? {1'b0, src_size} :
    {1'b0, dst_size};
  assign next_src_ptr = add_bytes(src_ptr, i_src_nbytes);
  assign next_dst_ptr = add_bytes(dst_ptr, i_src_nbytes);
  assign next_moved = moved + {14'h0000, i_src_nbytes};
  assign o_busy = ctrl[`DMACR_CTRL_EN] & (block_len != 17'h00000);
  assign o_src_req = o_busy;
  assign step = o_src_req & i_src_ack;
  assign o_src_addr = i_src_start + {16'h0000, src_ptr};
  assign o_dst_addr = dst_start + {16'h0000, dst_ptr};
  assign pat_hit = ctrl[`DMACR_CTRL_EN] & ctrl[`DMACR_CTRL_PAT] &
    i_pattern_match;

  // size used directly as byte count, all ones is 65,535
  assign ev_sdone = step & (next_src_ptr >= {1'b0, src_size});
  assign ev_shalf = step & (src_ptr < src_half) &
    (next_src_ptr >= {1'b0, src_half});
  // destination wrap and moved byte count
  assign ev_ddone = step & (next_dst_ptr >= {1'b0, dst_size});
  assign ev_moved = step & (next_moved >= block_len);
  assign ev_block = pat_hit | ev_moved;

  assign events = {ev_sdone, ev_shalf, 2'b00, ev_block, 3'b000};

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dst_start <= `DMACR_RST_WORD;
      src_size <= `DMACR_RST_HALF;
      dst_size <= `DMACR_RST_HALF;
    end else begin
      if (wr_dst_start) begin
        dst_start <= i_pwdata;
      end
      if (wr_src_size) begin
        src_size <= i_pwdata[15:0];
      end
      if (wr_dst_size) begin
        dst_size <= i_pwdata[15:0];
      end
    end
  end

  // control; hardware stop loses to a software write
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl <= `DMACR_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= i_pwdata[1:0];
    end else if (ev_block) begin
      ctrl[`DMACR_CTRL_EN] <= 1'b0;
    end
  end

  // source pointer; software restart of the channel rewinds it
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_ptr <= `DMACR_RST_HALF;
    end else if (wr_ctrl) begin
      src_ptr <= `DMACR_RST_HALF;
    end else if (ev_block) begin
      src_ptr <= `DMACR_RST_HALF;
    end else if (ev_sdone) begin
      src_ptr <= `DMACR_RST_HALF;
    end else if (step) begin
      src_ptr <= next_src_ptr[15:0];
    end
  end

  // destination pointer and moved byte count
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dst_ptr <= `DMACR_RST_HALF;
      moved <= `DMACR_RST_COUNT;
    end else if (wr_ctrl || ev_block) begin
      dst_ptr <= `DMACR_RST_HALF;
      moved <= `DMACR_RST_COUNT;
    end else if (step) begin
      if (ev_ddone) begin
        dst_ptr <= `DMACR_RST_HALF;
      end else begin
        dst_ptr <= next_dst_ptr[15:0];
      end
      moved <= next_moved;
    end
  end

  // sticky flags, mask and interrupt
  dmacr_irq u_irq (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_set(events),
    .i_clr_we(wr_stat),
    .i_clr_data(i_pwdata[7:0]),
    .i_mask_we(wr_mask),
    .i_mask_data(i_pwdata[7:0]),
    .o_status(status),
    .o_mask(mask),
    .o_irq(o_irq)
  );
endmodule // dmacr_top

// ### dmacr_properties.sv
// port assertions of the dma channel slice
`timescale 1ns/1ps
module dmacr_properties (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire [31:0] i_src_start,
  input wire [31:0] o_src_addr,
  input wire o_pslverr,
  input wire o_src_req,
  input wire i_src_ack,
  input wire i_pattern_match,
  input wire [2:0] i_src_nbytes,
  input wire o_busy,
  input wire o_irq
);
  default clocking dc @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire acc = i_psel & i_penable;
  wire rd = acc & !i_pwrite;
  chk_unmapped_err: assert property (acc && i_paddr > 8'h18 |->
    o_pslverr && o_prdata == 32'h0) else $error("unmapped access");
  chk_size_upper: assert property (rd && i_paddr[7:2] == 6'h1 |->
    o_prdata[31:16] == 16'h0) else $error("size upper");
  chk_dsize_upper: assert property (rd && i_paddr == 8'h08 |->
    o_prdata[31:16] == 16'h0) else $error("dsize upper");
  chk_ptr_upper: assert property (rd && i_paddr == 8'h0c |->
    o_prdata[31:16] == 16'h0) else $error("ptr upper");
  chk_req_start: assert property ($rose(o_src_req) |->
    $past(acc && i_pwrite)) else $error("req without write");
  chk_ptr_step: assert property (o_src_req && i_src_ack && !i_psel &&
    !i_pattern_match |=> o_src_addr == $past(o_src_addr) +
    $past(i_src_nbytes) || o_src_addr == i_src_start) else $error("step");
  chk_idle_hold: assert property (!i_src_ack && !i_psel &&
    !i_pattern_match |=> $stable(o_src_addr)) else $error("ptr moved");
  chk_done_rewind: assert property ($fell(o_busy) && !$past(i_psel)
    |-> o_src_addr == i_src_start) else $error("no rewind");
  chk_irq_hold: assert property (o_irq && !(acc && i_pwrite) |=> o_irq)
    else $error("irq dropped");
  cover property (o_irq);
  cover property ($fell(o_busy));
  cover property (acc && o_pslverr);
endmodule // dmacr_properties

// ### dmacr_mem_model.sv
// bus memory model answering source reads
`timescale 1ns/1ps
module dmacr_mem_model (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_req,
  input wire i_slow,
  input wire [2:0] i_nb,
  output reg o_ack,
  output reg [2:0] o_nbytes
);
  reg [2:0] cnt;
  wire go = i_req & (!i_slow | cnt == 3'h0);
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_nbytes <= 3'h7;
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
      o_ack <= go;
      o_nbytes <= go ? i_nb : ~o_nbytes;
    end
  end
endmodule // dmacr_mem_model

// ### dmacr_top_tb.sv
// testbench of the dma channel register slice
`timescale 1ns/1ps
module dmacr_top_tb;
  reg i_clk_sys = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  reg [7:0] i_paddr = 8'h0;
  reg [31:0] i_pwdata = 32'h0, i_src_start = 32'h1000_0000, q;
  reg i_pattern_match = 0, err, slow = 0;
  reg [2:0] nb = 3'h2;
  wire [31:0] o_prdata, o_src_addr, o_dst_addr;
  wire o_pready, o_pslverr, o_src_req, i_src_ack, o_busy, o_irq;
  wire [2:0] i_src_nbytes;
  integer fail_count = 0, checks = 0;
  dmacr_top DUT (.*);
  dmacr_mem_model MEM (.i_clk_sys, .i_rst_n, .i_req(o_src_req),
    .i_slow(slow), .i_nb(nb), .o_ack(i_src_ack), .o_nbytes(i_src_nbytes));
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task xf(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      @(posedge i_clk_sys);
      while (o_pready !== 1'b1) @(posedge i_clk_sys);
      q = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask
  task eq(input string n, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task ck(input [7:0] a, input [31:0] e);
    begin
      xf(1'b0, a, 32'h0);
      eq($sformatf("reg %h", a), e, q);
    end
  endtask
  task idle;
    begin
      @(posedge i_clk_sys);
      repeat (300) if (o_busy === 1'b1) @(negedge i_clk_sys);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) ck(8'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++) xf(1'b1, 8'(i * 4), 32'hffff_ffff);
    ck(8'h00, 32'hffff_ffff);
    ck(8'h04, 32'h0000_ffff);
    ck(8'h08, 32'h0000_ffff);
    ck(8'h0c, 32'h0);
    ck(8'h1c, 32'h0);
    eq("pslverr", 32'h1, {31'h0, err});
    $display("register test end");
    xf(1'b1, 8'h00, 32'h2000_0000);
    xf(1'b1, 8'h04, 32'h6);
    xf(1'b1, 8'h08, 32'h4);
    xf(1'b1, 8'h18, 32'hc8);
    xf(1'b1, 8'h10, 32'h1);
    idle;
    eq("irq", 32'h1, {31'h0, o_irq});
    eq("dst", 32'h2000_0000, o_dst_addr);
    eq("src", i_src_start, o_src_addr);
    ck(8'h14, 32'hc8);
    ck(8'h10, 32'h0);
    xf(1'b1, 8'h14, 32'hc8);
    ck(8'h14, 32'h0);
    eq("irq", 32'h0, {31'h0, o_irq});
    $display("transfer test end");
    slow <= 1'b1;
    nb <= 3'h1;
    xf(1'b1, 8'h18, 32'h0);
    xf(1'b1, 8'h04, 32'h100);
    xf(1'b1, 8'h10, 32'h3);
    repeat (12) @(posedge i_clk_sys);
    i_pattern_match <= 1'b1;
    @(posedge i_clk_sys);
    i_pattern_match <= 1'b0;
    idle;
    eq("src", i_src_start, o_src_addr);
    eq("irq", 32'h0, {31'h0, o_irq});
    ck(8'h14, 32'h8);
    $display("pattern test end");
    summarize;
  end
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // dmacr_top_tb
bind dmacr_top dmacr_properties chk (.*);
